// ---- include/vmts_pkg.sv ----
package vmts_pkg;

    // ----------------------------------------------------------------
    // Monitoring mode codes
    // ----------------------------------------------------------------
    localparam logic [4:0] MODE_NONE       = 5'h00;
    localparam logic [4:0] MODE_GRP_A      = 5'h06;
    localparam logic [4:0] MODE_GRP_B      = 5'h07;
    localparam logic [4:0] MODE_GRP_C      = 5'h08;
    localparam logic [4:0] MODE_GRP_D      = 5'h09;
    localparam logic [4:0] MODE_TWO_A      = 5'h04;
    localparam logic [4:0] MODE_TWO_B      = 5'h0B;
    localparam logic [4:0] MODE_TWO_C      = 5'h0D;
    localparam logic [4:0] MODE_SMART      = 5'h0E;

    // ----------------------------------------------------------------
    // Fault codes
    // ----------------------------------------------------------------
    localparam logic [7:0] FAULT_NONE      = 8'h00;
    localparam logic [7:0] FAULT_RELEVEL2  = 8'h06;
    localparam logic [7:0] FAULT_END_LVL   = 8'h08;
    localparam logic [7:0] FAULT_ZONE_A    = 8'h0A;
    localparam logic [7:0] FAULT_ZONE_B    = 8'h0B;

    // ----------------------------------------------------------------
    // Timing: timer unit is 0.1 s, tick derived from the clock
    // ----------------------------------------------------------------
    localparam int CLK_HZ            = 125_000_000;
    localparam int TICK_MS           = 100;
    localparam int TICK_CYCLES       = CLK_HZ / 1000 * TICK_MS;
    localparam int TIMER_W           = 8;
    localparam logic [7:0] TMR_GRP_DEF   = 8'h1E;  // 3,0 s
    localparam logic [7:0] TMR_TWO_DEF   = 8'h64;  // 10,0 s
    localparam logic [7:0] TMR_SMART_DEF = 8'h28;  // 4,0 s
    localparam logic [7:0] TMR_NOTEST    = 8'h03;  // 0,3 s

    typedef enum logic [2:0] {
        ST_IDLE, ST_STEP1, ST_PAUSE, ST_STEP2, ST_WAITLVL, ST_CHECK
    } vmts_state_type;

endpackage

// ---- core/vmts_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

// Three-stage input synchroniser; output changes when stages two and three agree
module vmts_sync (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic d,
    output logic      q
);
    logic s1_r, s2_r, s3_r, q_r;
    logic q_nxt;

    // Hold value until second and third stage agree
    always_comb begin
        q_nxt = (s2_r == s3_r) ? s3_r : q_r;
    end

    // Sample chain
    always_ff @(posedge clk) begin
        if (srst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q_r  <= 1'b0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end

    assign q = q_r;
endmodule

`default_nettype wire

// ---- core/vmts_sequencer.sv ----
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Three-step modes: down valve alone, one timer
// - Then all valves off for half timer
// - Then safety-down valve for full timer
// - Re-level needed at end: fault 8
// - Test starts on reset and bottom return
// - Three-step: brake output drives valve 20
// - Two-step modes: safety-down valve first step
// - Re-level during step restarts it afterwards
// - Two-step second step: descent valve, timer
// - Two re-levels within a step: fault 6
// - Two-step: brake drives unit safety-down valve
// - Smart mode: zone A 10, zone B 11
// - Mode none: no monitoring, no faults
module vmts_sequencer
    import vmts_pkg::*;
#(
    parameter int TICK_CYC = vmts_pkg::TICK_CYCLES
) (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic [4:0]                  mode,
    input  wire logic [vmts_pkg::TIMER_W-1:0] timer_cfg,
    input  wire logic                        bottom_return,
    input  wire logic                        relevel_req,
    input  wire logic                        smart_zone_a_fault,
    input  wire logic                        smart_zone_b_fault,
    input  wire logic                        down_cmd,
    output logic                             down_valve,
    output logic                             safety_down_valve,
    output logic                             descent_valve,
    output logic                             brake_command_output,
    output logic                             valve20_output,
    output logic                             test_busy,
    output logic                             unintended_movement_fault,
    output logic [7:0]                       fault_code
);
    import vmts_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic relevel_s, zone_a_s, zone_b_s, bottom_s;

    vmts_sync u_sync_lvl (.clk(clk), .srst(srst), .d(relevel_req),        .q(relevel_s));
    vmts_sync u_sync_za  (.clk(clk), .srst(srst), .d(smart_zone_a_fault), .q(zone_a_s));
    vmts_sync u_sync_zb  (.clk(clk), .srst(srst), .d(smart_zone_b_fault), .q(zone_b_s));
    vmts_sync u_sync_bot (.clk(clk), .srst(srst), .d(bottom_return),      .q(bottom_s));

    // Mode class decoders
    function automatic logic is_three(input logic [4:0] m);
        return (m == MODE_GRP_A) || (m == MODE_GRP_B) || (m == MODE_GRP_C) || (m == MODE_GRP_D);
    endfunction

    function automatic logic is_two(input logic [4:0] m);
        return (m == MODE_TWO_A) || (m == MODE_TWO_B) || (m == MODE_TWO_C);
    endfunction

    // ----------------------------------------------------------------
    // Tick generator
    // ----------------------------------------------------------------
    logic [31:0] tick_cnt_r, tick_cnt_nxt;
    logic        tick;

    // Free-running divider producing one-cycle tick
    always_comb begin
        tick         = (tick_cnt_r == 32'(TICK_CYC - 1));
        tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Test sequencer
    // ----------------------------------------------------------------
    vmts_state_type       state_r, state_nxt;
    logic [TIMER_W-1:0]   cnt_r, cnt_nxt;
    logic                 start_r, start_nxt;
    logic                 bot_d_r;
    logic [1:0]           lvl_cnt_r, lvl_cnt_nxt;
    logic                 lvl_d_r;
    logic                 dv_r, dv_nxt, sdv_nxt, desc_r, desc_nxt;
    logic                 umf_r, umf_nxt;
    logic [7:0]           code_r, code_nxt;
    logic                 step2_r, step2_nxt;
    logic                 lvl_rise;
    logic                 three, two;

    always_comb begin
        three        = is_three(mode);
        two          = is_two(mode);
        lvl_rise     = relevel_s && !lvl_d_r;
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        start_nxt    = start_r || (bottom_s && !bot_d_r);
        lvl_cnt_nxt  = lvl_cnt_r;
        step2_nxt    = step2_r;
        umf_nxt      = umf_r;
        code_nxt     = code_r;
        if (tick && cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
        case (state_r)
            ST_IDLE: begin
                if (start_r && (three || two)) begin
                    start_nxt   = 1'b0;
                    state_nxt   = ST_STEP1;
                    cnt_nxt     = timer_cfg;
                    lvl_cnt_nxt = 2'h0;
                    step2_nxt   = 1'b0;
                end else if (start_r) begin
                    start_nxt = 1'b0;                          // Other modes: no valve
                end
            end
            ST_STEP1, ST_STEP2: begin
                if (two && lvl_rise) begin
                    lvl_cnt_nxt = lvl_cnt_r + 2'h1;
                    if (lvl_cnt_r != 2'h0) begin
                        umf_nxt   = 1'b1;
                        code_nxt  = FAULT_RELEVEL2;
                        state_nxt = ST_IDLE;
                    end else begin
                        state_nxt = ST_WAITLVL;
                    end
                end else if (cnt_r == '0) begin
                    if (state_r == ST_STEP1 && three) begin
                        state_nxt = ST_PAUSE;
                        cnt_nxt   = timer_cfg >> 1;
                    end else if (state_r == ST_STEP1) begin
                        state_nxt   = ST_STEP2;
                        step2_nxt   = 1'b1;
                        cnt_nxt     = timer_cfg;
                        lvl_cnt_nxt = 2'h0;
                    end else if (three) begin
                        state_nxt = ST_CHECK;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_PAUSE: begin
                if (cnt_r == '0) begin
                    state_nxt = ST_STEP2;
                    step2_nxt = 1'b1;
                    cnt_nxt   = timer_cfg;
                end
            end
            ST_WAITLVL: begin
                if (!relevel_s) begin
                    state_nxt = step2_r ? ST_STEP2 : ST_STEP1; // Restart step
                    cnt_nxt   = timer_cfg;
                end
            end
            ST_CHECK: begin
                if (relevel_s) begin
                    umf_nxt  = 1'b1;
                    code_nxt = FAULT_END_LVL;
                end
                state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
        // Smart valve unit zone faults
        if (mode == MODE_SMART && zone_a_s) begin
            umf_nxt  = 1'b1;
            code_nxt = FAULT_ZONE_A;
        end else if (mode == MODE_SMART && zone_b_s) begin
            umf_nxt  = 1'b1;
            code_nxt = FAULT_ZONE_B;
        end
        // Mode none: idle, no faults
        if (mode == MODE_NONE) begin
            state_nxt = ST_IDLE;
            umf_nxt   = 1'b0;
            code_nxt  = FAULT_NONE;
        end
        // Valve drives per state and mode
        sdv_nxt  = (state_nxt == ST_STEP2 && three) ||
                   (state_nxt == ST_STEP1 && two);
        desc_nxt = (state_nxt == ST_STEP2 && two);
        dv_nxt   = (state_nxt == ST_STEP1 && three);
        if (state_nxt == ST_IDLE) begin
            dv_nxt   = three && down_cmd;
            desc_nxt = two && down_cmd;
        end
    end

    // Register sequencer state
    always_ff @(posedge clk) begin
        if (srst) begin
            state_r   <= ST_IDLE;
            cnt_r     <= '0;
            start_r   <= 1'b1;                                 // Reset starts a
            bot_d_r   <= 1'b0;
            lvl_d_r   <= 1'b0;
            lvl_cnt_r <= 2'h0;
            step2_r   <= 1'b0;
            dv_r      <= 1'b0;
            desc_r    <= 1'b0;
            umf_r     <= 1'b0;
            code_r    <= FAULT_NONE;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            start_r   <= start_nxt;
            bot_d_r   <= bottom_s;
            lvl_d_r   <= relevel_s;
            lvl_cnt_r <= lvl_cnt_nxt;
            step2_r   <= step2_nxt;
            dv_r      <= dv_nxt;
            desc_r    <= desc_nxt;
            umf_r     <= umf_nxt;
            code_r    <= code_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Dual down command outputs
    // ----------------------------------------------------------------
    logic brake_r, brake_nxt, v20_r, v20_nxt, busy_r, busy_nxt, sdo_r, sdo_nxt;

    // Second down command; safety-down pin merged before its flop
    always_comb begin
        v20_nxt   = is_three(mode) && down_cmd && (state_nxt == ST_IDLE);
        brake_nxt = v20_nxt ||
                    (is_two(mode) && down_cmd && (state_nxt == ST_IDLE));
        sdo_nxt   = sdv_nxt || (brake_nxt && !v20_nxt);
        busy_nxt  = (state_nxt != ST_IDLE);
    end

    // Register command outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            brake_r <= 1'b0;
            v20_r   <= 1'b0;
            sdo_r   <= 1'b0;
            busy_r  <= 1'b0;
        end else begin
            brake_r <= brake_nxt;
            v20_r   <= v20_nxt;
            sdo_r   <= sdo_nxt;
            busy_r  <= busy_nxt;
        end
    end

    assign down_valve                = dv_r;
    assign safety_down_valve         = sdo_r;
    assign descent_valve             = desc_r;
    assign brake_command_output      = brake_r;
    assign valve20_output            = v20_r;
    assign test_busy                 = busy_r;
    assign unintended_movement_fault = umf_r;
    assign fault_code                = code_r;
endmodule

`default_nettype wire

// ---- verif/vmts_sequencer_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none

module vmts_sequencer_monitor
    import vmts_pkg::*;
#(
    parameter int TICK_CYC = 4
) (
    input wire logic                         clk,
    input wire logic                         srst,
    input wire logic [4:0]                   mode,
    input wire logic [vmts_pkg::TIMER_W-1:0] timer_cfg,
    input wire logic                         down_cmd,
    input wire logic                         down_valve,
    input wire logic                         safety_down_valve,
    input wire logic                         descent_valve,
    input wire logic                         valve20_output,
    input wire logic                         test_busy,
    input wire logic                         unintended_movement_fault,
    input wire logic [7:0]                   fault_code
);
    // ------------------------------------------------------------
    // Mode groups and the nominal timer used by the bench
    // ------------------------------------------------------------
    wire logic grp = mode inside {MODE_GRP_A, MODE_GRP_B, MODE_GRP_C, MODE_GRP_D};
    wire logic two = mode inside {MODE_TWO_A, MODE_TWO_B, MODE_TWO_C};
    wire logic nom = (timer_cfg == 8'h04) && (TICK_CYC == 4);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ------------------------------------------------------------
    // Three-step sequence: 16 cycle step, 8 cycle pause, one tick slack
    // ------------------------------------------------------------
    sequence s_open; $rose(down_valve) && test_busy && grp && nom; endsequence
    sequence s_shut; $fell(down_valve) && test_busy && grp && nom; endsequence
    property p_open; s_open |-> down_valve[*8] ##[4:13] !down_valve; endproperty
    property p_pause;
        s_shut |-> (!safety_down_valve && !descent_valve)[*4] ##[1:10] safety_down_valve;
    endproperty
    property p_alone; test_busy && grp && down_valve |-> !safety_down_valve; endproperty
    property p_code8; fault_code == FAULT_END_LVL |-> grp || $past(grp); endproperty
    property p_code6; fault_code == FAULT_RELEVEL2 |-> two || $past(two); endproperty
    property p_sticky; unintended_movement_fault && mode != MODE_NONE |=> unintended_movement_fault;
    endproperty
    property p_none; mode == MODE_NONE ##1 mode == MODE_NONE |-> fault_code == FAULT_NONE;
    endproperty
    property p_brk3; (!test_busy && down_cmd && grp)[*2] |-> valve20_output; endproperty
    property p_brk2; (!test_busy && down_cmd && two)[*2] |-> safety_down_valve; endproperty
    a_open: assert property (p_open) else $error("down valve step length wrong");
    a_pause: assert property (p_pause) else $error("pause or second step wrong");
    a_alone: assert property (p_alone) else $error("down valve not alone");
    a_code8: assert property (p_code8) else $error("code 8 outside three-step");
    a_code6: assert property (p_code6) else $error("code 6 outside two-step");
    a_sticky: assert property (p_sticky) else $error("fault dropped");
    a_none: assert property (p_none) else $error("fault in mode none");
    a_brk3: assert property (p_brk3) else $error("valve 20 not driven");
    a_brk2: assert property (p_brk2) else $error("second command missing");
endmodule

bind vmts_sequencer vmts_sequencer_monitor #(.TICK_CYC(TICK_CYC)) vmts_sequencer_monitor_inst (
    .clk(clk), .srst(srst), .mode(mode), .timer_cfg(timer_cfg), .down_cmd(down_cmd),
    .down_valve(down_valve), .safety_down_valve(safety_down_valve),
    .descent_valve(descent_valve), .valve20_output(valve20_output), .test_busy(test_busy),
    .unintended_movement_fault(unintended_movement_fault), .fault_code(fault_code));

`default_nettype wire

// ---- verif/vmts_valve_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module vmts_valve_model (
    input  wire logic clk,
    input  wire logic relevel_cmd,
    input  wire logic zone_a_cmd,
    input  wire logic zone_b_cmd,
    output logic      relevel_req,
    output logic      smart_zone_a_fault,
    output logic      smart_zone_b_fault
);
    logic [1:0] lvl_r = 2'h0;
    logic       za_r  = 1'h0;
    logic       zb_r  = 1'h0;
    // Car re-levelling shows two cycles after it is commanded
    always_ff @(posedge clk) begin
        lvl_r <= {lvl_r[0], relevel_cmd};
    end
    assign relevel_req        = lvl_r[1];
    // Zone reports of the smart unit, launched on the clock edge
    always_ff @(posedge clk) begin
        za_r <= zone_a_cmd;
        zb_r <= zone_b_cmd;
    end
    assign smart_zone_a_fault = za_r;
    assign smart_zone_b_fault = zb_r;
endmodule

`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import vmts_pkg::*;
    logic       clk = 1'h0, srst = 1'h1, bottom_return = 1'h0, down_cmd = 1'h0;
    logic       relevel_cmd = 1'h0, zone_a_cmd = 1'h0, zone_b_cmd = 1'h0;
    logic [4:0] mode = MODE_NONE;
    logic [7:0] timer_cfg = 8'h04;
    wire logic  rl, za, zb, dv, sv, ev, brake, v20, busy, umf;
    wire logic [7:0] code;
    int         num_errors = 0, checks = 0, cycles = 0, n;
    vmts_valve_model vmts_valve_model_inst (.clk(clk), .relevel_cmd(relevel_cmd),
        .zone_a_cmd(zone_a_cmd), .zone_b_cmd(zone_b_cmd), .relevel_req(rl),
        .smart_zone_a_fault(za), .smart_zone_b_fault(zb));
    vmts_sequencer #(.TICK_CYC(4)) vmts_sequencer_inst (.clk(clk), .srst(srst), .mode(mode),
        .timer_cfg(timer_cfg), .bottom_return(bottom_return), .relevel_req(rl),
        .smart_zone_a_fault(za), .smart_zone_b_fault(zb), .down_cmd(down_cmd),
        .down_valve(dv), .safety_down_valve(sv), .descent_valve(ev),
        .brake_command_output(brake), .valve20_output(v20), .test_busy(busy),
        .unintended_movement_fault(umf), .fault_code(code));
    // ------------------------------------------------------------
    // Clock, hang guard and shared helpers
    // ------------------------------------------------------------
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return dv;
            1: return sv;
            2: return ev;
            3: return busy;
            default: return umf;
        endcase
    endfunction
    // Wait a bounded time for a signal to reach a level
    task automatic await(input int s, input logic lvl);
        for (int i = 0; i < 300 && sig(s) !== lvl; i++) step(1);
    endtask
    // Length of the next high phase of a signal
    task automatic span(input int s);
        await(s, 1'h1);
        for (n = 0; n < 300 && sig(s) === 1'h1; n++) step(1);
        chk(8'(n >= 12 && n <= 20), 8'h01);
    endtask
    task automatic kick(input logic [4:0] m);
        @(posedge clk);
        mode <= m;
        bottom_return <= 1'h1;
        repeat (6) @(posedge clk);
        bottom_return <= 1'h0;
        #1;
    endtask
    task automatic lvl(input int hi, input int lo);
        @(posedge clk) relevel_cmd <= 1'h1;
        step(hi);
        relevel_cmd <= 1'h0;
        step(lo);
    endtask
    task automatic clear;
        @(posedge clk) mode <= MODE_NONE;
        step(3);
        chk(code, FAULT_NONE);
        chk(8'(umf), 8'h00);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_three;
        logic [4:0] modes [3] = '{MODE_GRP_B, MODE_GRP_C, MODE_GRP_D};
        step(2);
        chk(8'(busy), 8'h01);
        span(0);
        span(1);
        await(3, 1'h0);
        chk(code, FAULT_NONE);
        foreach (modes[i]) begin
            kick(modes[i]);
            await(1, 1'h1);
            @(posedge clk) relevel_cmd <= 1'h1;
            await(3, 1'h0);
            step(2);
            chk(code, FAULT_END_LVL);
            relevel_cmd <= 1'h0;
            clear();
        end
    endtask
    task automatic t_two;
        logic [4:0] modes [3] = '{MODE_TWO_A, MODE_TWO_B, MODE_TWO_C};
        foreach (modes[i]) begin
            kick(modes[i]);
            span(1);
            span(2);
            await(3, 1'h0);
            chk(code, FAULT_NONE);
            clear();
        end
        kick(MODE_TWO_A);
        await(1, 1'h1);
        lvl(6, 0);
        for (n = 0; n < 300 && ev !== 1'h1; n++) step(1);
        chk(8'(n >= 12), 8'h01);
        await(3, 1'h0);
        clear();
        kick(MODE_TWO_B);
        await(1, 1'h1);
        lvl(6, 2);
        lvl(6, 0);
        await(4, 1'h1);
        chk(code, FAULT_RELEVEL2);
        clear();
    endtask
    task automatic t_smart;
        kick(5'h05);
        chk(8'(busy), 8'h00);
        chk(8'(umf), 8'h00);
        clear();
        kick(MODE_SMART);
        zone_a_cmd <= 1'h1;
        await(4, 1'h1);
        chk(code, FAULT_ZONE_A);
        zone_a_cmd <= 1'h0;
        clear();
        kick(MODE_SMART);
        zone_b_cmd <= 1'h1;
        await(4, 1'h1);
        chk(code, FAULT_ZONE_B);
        zone_b_cmd <= 1'h0;
        clear();
    endtask
    task automatic t_brake;
        @(posedge clk) mode <= MODE_GRP_C;
        down_cmd <= 1'h1;
        step(4);
        chk(8'(v20), 8'h01);
        chk({6'h00, dv, brake}, 8'h03);
        @(posedge clk) mode <= MODE_TWO_C;
        step(4);
        chk({6'h00, sv, brake}, 8'h03);
        chk({6'h00, ev, v20}, 8'h02);
        @(posedge clk) down_cmd <= 1'h0;
        clear();
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'h0;
        mode <= MODE_GRP_A;
        t_three();
        t_two();
        t_smart();
        t_brake();
        report_and_stop();
    end
endmodule

`default_nettype wire
